// [inc/tmrclk_pkg.sv]
// Shared constants and carrier types for the timer clocking and event routing block.
// Assumes a single system clock domain; every pulse here is one system clock wide.
package tmrclk_pkg;

  // Counter widths
  localparam int unsigned CNT_W     = 16;
  localparam int unsigned BYTE_W    = 8;

  // Divider figures
  localparam int unsigned SYS_DIV   = 12;
  localparam int unsigned FAST_DIV  = 4;
  localparam int unsigned SLOW_MULT = 4;
  localparam int unsigned EXT_DIV   = 8;
  localparam int unsigned DIV_CNT_W = 6;

  // Reset value and divider terminal counts
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic [3:0]  DIV12_MAX = 4'hB;
  localparam logic [1:0]  QUAD_MAX  = 2'h3;

  // Field positions of the 13-bit layout
  localparam int unsigned LOW5_MSB  = 4;
  localparam int unsigned HIGH_LSB  = 8;

  // Modes of timers zero and one
  typedef enum logic [1:0] {
    MODE_13    = 2'h0,
    MODE_16    = 2'h1,
    MODE_8RELD = 2'h2,
    MODE_SPLIT = 2'h3
  } tmrclk_mode_t;

  // Shared prescaler selection
  typedef enum logic [1:0] {
    PRE_DIV12 = 2'h0,
    PRE_DIV4  = 2'h1,
    PRE_DIV48 = 2'h2,
    PRE_EXT8  = 2'h3
  } tmrclk_pre_t;

  // Clock choice of timers two and three
  typedef enum logic [1:0] {
    SRC_SYS   = 2'h0,
    SRC_DIV12 = 2'h1,
    SRC_EXT8  = 2'h2
  } tmrclk_src_t;

  // Serial bus clock rate choice
  typedef enum logic [1:0] {
    SBUS_ZERO   = 2'h0,
    SBUS_ONE    = 2'h1,
    SBUS_TWO_HI = 2'h2,
    SBUS_TWO_LO = 2'h3
  } tmrclk_sbus_t;

  typedef struct packed {
    logic         run;
    logic         counter_sel;
    tmrclk_mode_t mode;
  } tmrclk_t01_cfg_t;

  typedef struct packed {
    logic        run;
    logic        split;
    tmrclk_src_t clk_sel;
    logic        cap_en;
  } tmrclk_t23_cfg_t;

  typedef struct packed {
    logic        strobe;
    logic [15:0] value;
  } tmrclk_load_t;

endpackage

// [hdl/tmrclk_reload.sv]
// Auto-reload timer with split 8-bit mode and a capture register.
// Assumes tick and capture pulses already lie in the clk_i domain.
`timescale 1ns/1ns
`default_nettype none

module tmrclk_reload (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  // Control
  input  wire logic                        tick_i,
  input  wire tmrclk_pkg::tmrclk_t23_cfg_t cfg_i,
  input  wire tmrclk_pkg::tmrclk_load_t    load_i,
  input  wire logic [15:0]                 reload_i,
  input  wire logic                        cap_trig_i,
  // Status
  output logic [15:0]                      cnt_o,
  output logic [15:0]                      cap_o,
  output logic                             hi_ovf_o,
  output logic                             lo_ovf_o
);

  logic [15:0] next_cnt;
  logic        next_hi;
  logic        next_lo;

  always_comb begin
    next_cnt = cnt_o;
    next_hi  = 1'b0;
    next_lo  = 1'b0;
    if (load_i.strobe) begin
      next_cnt = load_i.value;
    end else if (cfg_i.split) begin
      // Low byte always runs in split mode; and
      if (tick_i) begin
        next_lo = &cnt_o[7:0];
        next_cnt[7:0] = next_lo ? reload_i[7:0] : cnt_o[7:0] + 8'h01;
      end
      if (tick_i && cfg_i.run) begin
        next_hi = &cnt_o[15:8];
        next_cnt[15:8] = next_hi ? reload_i[15:8] : cnt_o[15:8] + 8'h01;
      end
    end else if (tick_i && cfg_i.run) begin
      next_lo  = &cnt_o[7:0];
      next_hi  = &cnt_o;
      next_cnt = next_hi ? reload_i : cnt_o + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_o    <= tmrclk_pkg::CNT_RST;
      hi_ovf_o <= 1'b0;
      lo_ovf_o <= 1'b0;
    end else begin
      cnt_o    <= next_cnt;
      hi_ovf_o <= next_hi;
      lo_ovf_o <= next_lo;
    end
  end

  // Capture of the running count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cap_o <= tmrclk_pkg::CNT_RST;
    end else if (cfg_i.cap_en && cap_trig_i) begin
      cap_o <= cnt_o; // and
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  reload_full_a : assert property (
    (tick_i && cfg_i.run && !cfg_i.split && !load_i.strobe && cnt_o == 16'hFFFF)
      |=> (hi_ovf_o && cnt_o == $past(reload_i)))
    else $error("Full overflow did not reload");

  split_low_a : assert property (
    (tick_i && cfg_i.split && !load_i.strobe && cnt_o[7:0] == 8'hFF)
      |=> (lo_ovf_o && (hi_ovf_o == $past(cfg_i.run && cnt_o[15:8] == 8'hFF))))
    else $error("Split low overflow wrong");

  capture_take_a : assert property (
    (cfg_i.cap_en && cap_trig_i) |=> cap_o == $past(cnt_o))
    else $error("Capture missed count");

endmodule

`default_nettype wire

// [hdl/tmrclk_top.sv]
// Four counter/timers with clock selection, event counting and overflow routing.
// Assumes all inputs except the pins are in the clk_i domain; pins are synchronised here.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Four timers exist: two classic 16-bit counter/timers and two 16-bit auto-reload timers.
// - Timers zero and one run as 13-bit, 16-bit, 8-bit reload, or split 8-bit on timer zero only.
// - Timers two and three are identical, each a 16-bit reload or two 8-bit reload timers.
// - Timer two captures its count on an edge of the external capture input.
// - Timer three captures its count on an edge of the low-frequency oscillator output.
// - Timers zero and one pick among five clock sources through select bits and a prescale field.
// - Each of timers zero and one runs from the shared prescaled clock or the system clock.
// - Timers two and three run from the system clock, the clock over 12, or the oscillator over 8.
// - In counter function a falling edge on the event pin adds one to the count.
// - All timer overflows are exported, with separate high and low ones for timers two and three.
// - The high overflow of timers two and three comes from the full or high-byte counter.
// - Serial port, bus timeout and counter array each take their own timer overflow; the serial bus picks one of four.
// - A set select bit clocks the timer from the system clock, a clear one from the prescaler.
// - The oscillator over 8 source is synchronised to the system clock first.
module tmrclk_top #(
  parameter int unsigned EXT_DIV = tmrclk_pkg::EXT_DIV
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  // Pins
  input  wire logic                        timer_zero_event_pin_i,
  input  wire logic                        timer_one_event_pin_i,
  input  wire logic                        ext_osc_i,
  input  wire logic                        lfo_i,
  input  wire logic                        capture_pin_i,
  // Clock selection
  input  wire logic                        timer_zero_sysclk_select_i,
  input  wire logic                        timer_one_sysclk_select_i,
  input  wire tmrclk_pkg::tmrclk_pre_t     prescale_select_field_i,
  input  wire tmrclk_pkg::tmrclk_sbus_t    serial_bus_src_i,
  // Timer control
  input  wire tmrclk_pkg::tmrclk_t01_cfg_t zero_cfg_i,
  input  wire tmrclk_pkg::tmrclk_t01_cfg_t one_cfg_i,
  input  wire tmrclk_pkg::tmrclk_t23_cfg_t two_cfg_i,
  input  wire tmrclk_pkg::tmrclk_t23_cfg_t three_cfg_i,
  input  wire tmrclk_pkg::tmrclk_load_t    zero_load_i,
  input  wire tmrclk_pkg::tmrclk_load_t    one_load_i,
  input  wire tmrclk_pkg::tmrclk_load_t    two_load_i,
  input  wire tmrclk_pkg::tmrclk_load_t    three_load_i,
  input  wire logic [15:0]                 two_reload_i,
  input  wire logic [15:0]                 three_reload_i,
  // Counts and captures
  output logic [15:0]                      zero_cnt_o,
  output logic [15:0]                      one_cnt_o,
  output logic [15:0]                      two_cnt_o,
  output logic [15:0]                      three_cnt_o,
  output logic [15:0]                      two_capture_o,
  output logic [15:0]                      three_capture_o,
  // Overflow events
  output logic                             zero_ovf_o,
  output logic                             zero_hi_ovf_o,
  output logic                             one_ovf_o,
  output logic                             two_hi_ovf_o,
  output logic                             two_lo_ovf_o,
  output logic                             three_hi_ovf_o,
  output logic                             three_lo_ovf_o,
  // Peripheral ticks
  output logic                             serial_port_baud_tick_o,
  output logic                             serial_bus_clk_tick_o,
  output logic                             serial_bus_timeout_tick_o,
  output logic                             counter_array_clk_tick_o
);

  if (EXT_DIV < 2 || EXT_DIV > 64) begin : g_chk
    $error("EXT_DIV must lie between 2 and 64");
  end

  localparam logic [5:0] EXT_MAX = 6'(EXT_DIV - 1);

  // Pin synchronisers: stage 1, stage 2, delayed stage 2
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic       zero_fall;
  logic       one_fall;
  logic       ext_rise;
  logic       lfo_rise;
  logic       cap_rise;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
    end else begin
      // Two stages before any logic; and
      pin_s1 <= {capture_pin_i, lfo_i, ext_osc_i, timer_one_event_pin_i, timer_zero_event_pin_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign zero_fall = pin_s3[0] & ~pin_s2[0];
  assign one_fall  = pin_s3[1] & ~pin_s2[1];
  assign ext_rise  = pin_s2[2] & ~pin_s3[2];
  assign lfo_rise  = pin_s2[3] & ~pin_s3[3];
  assign cap_rise  = pin_s2[4] & ~pin_s3[4];

  // Dividers
  logic [3:0] div12_cnt;
  logic [1:0] div4_cnt;
  logic [1:0] div48_cnt;
  logic [5:0] ext_cnt;
  logic       tick12;
  logic       tick4;
  logic       tick48;
  logic       ext_tick;

  assign tick12   = (div12_cnt == tmrclk_pkg::DIV12_MAX);
  assign tick4    = (div4_cnt == tmrclk_pkg::QUAD_MAX);
  assign tick48   = tick12 && (div48_cnt == tmrclk_pkg::QUAD_MAX);
  assign ext_tick = ext_rise && (ext_cnt == EXT_MAX);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div12_cnt <= 4'h0;
      div4_cnt  <= 2'h0;
      div48_cnt <= 2'h0;
    end else begin
      div12_cnt <= tick12 ? 4'h0 : div12_cnt + 4'h1;
      div4_cnt  <= div4_cnt + 2'h1;
      if (tick12) begin
        div48_cnt <= div48_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_cnt <= 6'h00;
    end else if (ext_rise) begin
      ext_cnt <= ext_tick ? 6'h00 : ext_cnt + 6'h01;
    end
  end

  // Shared prescaled clock and timer clocks
  logic pre_tick;
  logic zero_tmr_tick;
  logic one_tmr_tick;

  always_comb begin
    case (prescale_select_field_i)
      tmrclk_pkg::PRE_DIV12: pre_tick = tick12;
      tmrclk_pkg::PRE_DIV4:  pre_tick = tick4;
      tmrclk_pkg::PRE_DIV48: pre_tick = tick48;
      default:               pre_tick = ext_tick;
    endcase
  end

  assign zero_tmr_tick = timer_zero_sysclk_select_i | pre_tick; // and
  assign one_tmr_tick  = timer_one_sysclk_select_i | pre_tick;

  // One step of a classic timer: {overflow, next count}
  function automatic logic [16:0] tmrclk_step(input tmrclk_pkg::tmrclk_mode_t mode, input logic [15:0] cnt);
    logic [12:0] c13;
    c13 = {cnt[15:8], cnt[4:0]} + 13'h0001;
    case (mode)
      tmrclk_pkg::MODE_13:    tmrclk_step = {(c13 == 13'h0000), c13[12:5], cnt[7:5], c13[4:0]};
      tmrclk_pkg::MODE_16:    tmrclk_step = {(&cnt), cnt + 16'h0001};
      tmrclk_pkg::MODE_8RELD: tmrclk_step = (&cnt[7:0]) ? {1'b1, cnt[15:8], cnt[15:8]}
                                                        : {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
      default:                tmrclk_step = {(&cnt[7:0]), cnt[15:8], cnt[7:0] + 8'h01};
    endcase
  endfunction

  logic        zero_split;
  logic        zero_en;
  logic        one_en;
  logic [15:0] next_zero;
  logic [15:0] next_one;
  logic        next_zero_ovf;
  logic        next_zero_hi;
  logic        next_one_ovf;

  assign zero_split = (zero_cfg_i.mode == tmrclk_pkg::MODE_SPLIT);
  assign zero_en    = zero_cfg_i.run && (zero_cfg_i.counter_sel ? zero_fall : zero_tmr_tick);
  // Timer one loses its pin while timer zero is split, and stops in its own split mode
  assign one_en     = one_cfg_i.run && (one_cfg_i.mode != tmrclk_pkg::MODE_SPLIT) &&
                      ((one_cfg_i.counter_sel && !zero_split) ? one_fall : one_tmr_tick);

  always_comb begin
    next_zero     = zero_cnt_o;
    next_zero_ovf = 1'b0;
    next_zero_hi  = 1'b0;
    if (zero_en) begin
      {next_zero_ovf, next_zero} = tmrclk_step(zero_cfg_i.mode, zero_cnt_o);
    end
    // Split high byte: timer clock only, run by timer one's run bit
    if (zero_split && one_cfg_i.run && zero_tmr_tick) begin
      next_zero[15:8] = zero_cnt_o[15:8] + 8'h01;
      next_zero_hi    = &zero_cnt_o[15:8];
    end
    if (zero_load_i.strobe) begin
      next_zero     = zero_load_i.value;
      next_zero_ovf = 1'b0;
      next_zero_hi  = 1'b0;
    end
  end

  always_comb begin
    next_one     = one_cnt_o;
    next_one_ovf = 1'b0;
    if (one_en) begin
      {next_one_ovf, next_one} = tmrclk_step(one_cfg_i.mode, one_cnt_o);
    end
    if (one_load_i.strobe) begin
      next_one     = one_load_i.value;
      next_one_ovf = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      zero_cnt_o    <= tmrclk_pkg::CNT_RST;
      one_cnt_o     <= tmrclk_pkg::CNT_RST;
      zero_ovf_o    <= 1'b0;
      zero_hi_ovf_o <= 1'b0;
      one_ovf_o     <= 1'b0;
    end else begin
      zero_cnt_o    <= next_zero;
      one_cnt_o     <= next_one;
      zero_ovf_o    <= next_zero_ovf;
      zero_hi_ovf_o <= next_zero_hi;
      one_ovf_o     <= next_one_ovf;
    end
  end

  // Timers two and three
  logic two_tick;
  logic three_tick;

  function automatic logic tmrclk_src(input tmrclk_pkg::tmrclk_src_t sel, input logic t12, input logic t8);
    case (sel)
      tmrclk_pkg::SRC_SYS:   tmrclk_src = 1'b1;
      tmrclk_pkg::SRC_DIV12: tmrclk_src = t12;
      tmrclk_pkg::SRC_EXT8:  tmrclk_src = t8;
      default:               tmrclk_src = 1'b0;
    endcase
  endfunction

  assign two_tick   = tmrclk_src(two_cfg_i.clk_sel, tick12, ext_tick);
  assign three_tick = tmrclk_src(three_cfg_i.clk_sel, tick12, ext_tick);

  tmrclk_reload u_two (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .tick_i     (two_tick),
    .cfg_i      (two_cfg_i),
    .load_i     (two_load_i),
    .reload_i   (two_reload_i),
    .cap_trig_i (cap_rise),
    .cnt_o      (two_cnt_o),
    .cap_o      (two_capture_o),
    .hi_ovf_o   (two_hi_ovf_o),
    .lo_ovf_o   (two_lo_ovf_o)
  );

  tmrclk_reload u_three (
    .clk_i      (clk_i),
    .srst_i     (srst_i),
    .tick_i     (three_tick),
    .cfg_i      (three_cfg_i),
    .load_i     (three_load_i),
    .reload_i   (three_reload_i),
    .cap_trig_i (lfo_rise),
    .cnt_o      (three_cnt_o),
    .cap_o      (three_capture_o),
    .hi_ovf_o   (three_hi_ovf_o),
    .lo_ovf_o   (three_lo_ovf_o)
  );

  // Peripheral routing
  logic sbus_pick;

  always_comb begin
    case (serial_bus_src_i)
      tmrclk_pkg::SBUS_ZERO:   sbus_pick = zero_ovf_o;
      tmrclk_pkg::SBUS_ONE:    sbus_pick = one_ovf_o;
      tmrclk_pkg::SBUS_TWO_HI: sbus_pick = two_hi_ovf_o;
      default:                 sbus_pick = two_lo_ovf_o;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      serial_port_baud_tick_o   <= 1'b0;
      serial_bus_clk_tick_o     <= 1'b0;
      serial_bus_timeout_tick_o <= 1'b0;
      counter_array_clk_tick_o  <= 1'b0;
    end else begin
      serial_port_baud_tick_o   <= one_ovf_o;
      serial_bus_clk_tick_o     <= sbus_pick;
      serial_bus_timeout_tick_o <= three_hi_ovf_o;
      counter_array_clk_tick_o  <= zero_ovf_o;
    end
  end

  // Cycles since the last oscillator tick, saturating
  localparam logic [7:0] EXT_GAP_MIN = 8'(2 * EXT_DIV - 1);
  logic [7:0]            ext_gap;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_gap <= 8'hFF;
    end else begin
      ext_gap <= ext_tick ? 8'h00 : ext_gap + 8'(ext_gap != 8'hFF);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence zero_pin_fall_s;
    pin_s2[0] ##1 (!pin_s2[0] && zero_cfg_i.run && zero_cfg_i.counter_sel &&
                   zero_cfg_i.mode == tmrclk_pkg::MODE_16 && !zero_load_i.strobe);
  endsequence

  sequence zero_timer_run_s;
    zero_cfg_i.run && !zero_cfg_i.counter_sel && zero_cfg_i.mode == tmrclk_pkg::MODE_16 && !zero_load_i.strobe;
  endsequence

  pin_edge_count_a : assert property (
    zero_pin_fall_s |=> zero_cnt_o == $past(zero_cnt_o) + 16'h0001)
    else $error("Falling edge not counted");

  sysclk_rate_a : assert property (
    (zero_timer_run_s and timer_zero_sysclk_select_i) |=> zero_cnt_o == $past(zero_cnt_o) + 16'h0001)
    else $error("System clock select did not count");

  prescale_hold_a : assert property (
    (zero_timer_run_s and (!timer_zero_sysclk_select_i && !pre_tick)) |=> zero_cnt_o == $past(zero_cnt_o))
    else $error("Count moved without prescale tick");

  thirteen_wrap_a : assert property (
    (zero_en && !zero_load_i.strobe && zero_cfg_i.mode == tmrclk_pkg::MODE_13 &&
     zero_cnt_o[15:8] == 8'hFF && zero_cnt_o[4:0] == 5'h1F)
      |=> (zero_ovf_o && zero_cnt_o[15:8] == 8'h00 && zero_cnt_o[4:0] == 5'h00))
    else $error("13-bit wrap wrong");

  div12_gap_a : assert property (
    tick12 |=> !tick12 [*8])
    else $error("Divide by 12 too fast");

  ext_div_gap_a : assert property (
    ext_tick |-> ext_gap >= EXT_GAP_MIN)
    else $error("Oscillator divider too fast");

  baud_route_a : assert property (
    serial_port_baud_tick_o == $past(one_ovf_o) && counter_array_clk_tick_o == $past(zero_ovf_o))
    else $error("Serial or array tick misrouted");

  timeout_route_a : assert property (
    serial_bus_timeout_tick_o == $past(three_hi_ovf_o))
    else $error("Timeout tick misrouted");

endmodule

`default_nettype wire

// [testbench/tmrclk_far.sv]
// Far-side pin model: event inputs, external oscillator and capture sources.
// Assumes the bench clock; pins move 1 ns after a rising edge of clk_i.
`timescale 1ns/1ns
`default_nettype none

module tmrclk_far (
  // Clock
  input  wire logic clk_i,
  // Pins
  output logic      ev0_o,
  output logic      ev1_o,
  output logic      osc_o,
  output logic      lfo_o,
  output logic      cap_o
);
  initial begin
    {ev0_o, ev1_o} = 2'h3;
    {osc_o, lfo_o, cap_o} = 3'h0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Two cycles per level, so events come at a quarter of the clock
  task automatic events(input int n, input logic pin);
    for (int i = 0; i < n; i++) begin
      wait_clk(2);
      if (pin) begin
        ev1_o = 1'b0;
      end else begin
        ev0_o = 1'b0;
      end
      wait_clk(2);
      {ev0_o, ev1_o} = 2'h3;
    end
  endtask

  // Oscillator stands low between bursts
  task automatic osc_edges(input int n);
    for (int i = 0; i < n; i++) begin
      wait_clk(2);
      osc_o = 1'b1;
      wait_clk(2);
      osc_o = 1'b0;
    end
  endtask

  // One capture pulse: 0 on the capture pin, 1 on the oscillator output
  task automatic pulse(input logic src);
    if (src) begin
      lfo_o = 1'b1;
    end else begin
      cap_o = 1'b1;
    end
    wait_clk(3);
    if (src) begin
      lfo_o = 1'b0;
    end else begin
      cap_o = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// [testbench/tmrclk_top_bench.sv]
// Self-checking bench for the timer clocking and event routing block.
// Assumes the pin model tmrclk_far; inputs move 1 ns after each rising edge.
`timescale 1ns/1ns
`default_nettype none

module tmrclk_top_bench;
  localparam int unsigned EXT_N = 4;
  logic                        clk_i;
  logic                        srst_i;
  logic                        ev0, ev1, osc, lfo, capp, zsel, osel;
  tmrclk_pkg::tmrclk_pre_t     pre;
  tmrclk_pkg::tmrclk_sbus_t    sbus;
  tmrclk_pkg::tmrclk_t01_cfg_t zc, oc;
  tmrclk_pkg::tmrclk_t23_cfg_t tc, hc;
  tmrclk_pkg::tmrclk_load_t    zl, ol, tl, hl;
  logic [15:0]                 trl, hrl, zn, n1, tn, hn, tcap, hcap, s0, s1, s2;
  logic                        zo, zho, oo, tho, tlo, hho, hlo, baud, sclk, stmo, arr;
  logic [17:0]                 ez, eo;
  int                          error_cnt = 0;
  int                          num_checks = 0;
  int                          seed, v, n;
  int                          rate1[4] = '{4, 12, 1, 48};
  int                          sel2[4] = '{1, 0, 3, 1};
  int                          rate2[4] = '{4, 48, 0, 4};

  tmrclk_top #(.EXT_DIV(EXT_N)) i_dut (
    .clk_i(clk_i), .srst_i(srst_i),
    .timer_zero_event_pin_i(ev0), .timer_one_event_pin_i(ev1),
    .ext_osc_i(osc), .lfo_i(lfo), .capture_pin_i(capp),
    .timer_zero_sysclk_select_i(zsel), .timer_one_sysclk_select_i(osel),
    .prescale_select_field_i(pre), .serial_bus_src_i(sbus),
    .zero_cfg_i(zc), .one_cfg_i(oc), .two_cfg_i(tc), .three_cfg_i(hc),
    .zero_load_i(zl), .one_load_i(ol), .two_load_i(tl), .three_load_i(hl),
    .two_reload_i(trl), .three_reload_i(hrl),
    .zero_cnt_o(zn), .one_cnt_o(n1), .two_cnt_o(tn), .three_cnt_o(hn),
    .two_capture_o(tcap), .three_capture_o(hcap),
    .zero_ovf_o(zo), .zero_hi_ovf_o(zho), .one_ovf_o(oo),
    .two_hi_ovf_o(tho), .two_lo_ovf_o(tlo), .three_hi_ovf_o(hho), .three_lo_ovf_o(hlo),
    .serial_port_baud_tick_o(baud), .serial_bus_clk_tick_o(sclk),
    .serial_bus_timeout_tick_o(stmo), .counter_array_clk_tick_o(arr)
  );

  tmrclk_far i_far (.clk_i(clk_i), .ev0_o(ev0), .ev1_o(ev1), .osc_o(osc), .lfo_o(lfo), .cap_o(capp));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Next count of timer zero or one: {high ovf, ovf, count}
  function automatic logic [17:0] t01_next(input int m, input int x);
    int lo;
    int hi;
    int c;
    lo = x & 255;
    hi = (x >> 8) & 255;
    c = ((hi << 5) | (lo & 31)) + 1;
    case (m)
      0: return {1'b0, c == 8192, 8'(c >> 5), 3'(lo >> 5), 5'(c)};
      1: return {1'b0, x == 65535, 16'(x + 1)};
      2: return {1'b0, lo == 255, 8'(hi), 8'((lo == 255) ? hi : lo + 1)};
      default: return {hi == 255, lo == 255, 8'(hi + 1), 8'(lo + 1)};
    endcase
  endfunction

  initial begin
    #4000000;
    error_cnt++;
    finish_test();
  end

  initial begin
    seed = 7;
    srst_i = 1'b1;
    {zsel, osel} = 2'h0;
    pre = tmrclk_pkg::PRE_DIV12;
    sbus = tmrclk_pkg::SBUS_ZERO;
    {zc, oc, tc, hc, zl, ol, tl, hl, trl, hrl} = '0;
    step(8);
    srst_i = 1'b0;
    step(1);
    check(zn | n1 | tn | hn | tcap | hcap, 16'h0000);
    $display("test reset done");
    zsel = 1'b1;
    osel = 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int j = 0; j < 3; j++) begin
        v = (j == 0) ? 32'hFFFF : (j == 1) ? 32'h40FF : $random(seed) & 32'hFFFF;
        sbus = (j == 1) ? tmrclk_pkg::SBUS_ONE : tmrclk_pkg::SBUS_ZERO;
        zc.mode = tmrclk_pkg::tmrclk_mode_t'(m);
        oc.mode = (m == 3) ? tmrclk_pkg::MODE_16 : zc.mode;
        zl = '{1'b1, 16'(v)};
        ol = zl;
        step(1);
        zl.strobe = 1'b0;
        ol.strobe = 1'b0;
        zc.run = 1'b1;
        oc.run = 1'b1;
        ez = t01_next(m, v);
        eo = t01_next((m == 3) ? 1 : m, v);
        step(1);
        zc.run = 1'b0;
        oc.run = 1'b0;
        check(zn, ez[15:0]);
        check({zho, zo}, ez[17:16]);
        check(n1, eo[15:0]);
        check(oo, eo[16]);
        step(1);
        check({arr, baud, sclk}, {ez[16], eo[16], (j == 1) ? eo[16] : ez[16]});
      end
    end
    $display("test modes done");
    zc = '{1'b0, 1'b1, tmrclk_pkg::MODE_16};
    oc = zc;
    zl = '{1'b1, 16'h0000};
    ol = zl;
    step(1);
    zl.strobe = 1'b0;
    ol.strobe = 1'b0;
    zc.run = 1'b1;
    oc.run = 1'b1;
    n = ($random(seed) & 7) + 1;
    i_far.events(n, 1'b0);
    i_far.events(n, 1'b1);
    for (int i = 0; i < 12 && {zn, n1} !== {16'(n), 16'(n)}; i++) step(1);
    check(zn, 16'(n));
    check(n1, 16'(n));
    if ({zn, n1} !== {16'(n), 16'(n)}) finish_test();
    zc.run = 1'b0;
    $display("test events done");
    oc = '{1'b1, 1'b0, tmrclk_pkg::MODE_16};
    zc = oc;
    tc = '{1'b1, 1'b0, tmrclk_pkg::SRC_SYS, 1'b0};
    for (int k = 0; k < 4; k++) begin
      zsel = (k == 3);
      osel = (k == 3);
      pre = tmrclk_pkg::tmrclk_pre_t'(k % 3);
      tc.clk_sel = tmrclk_pkg::tmrclk_src_t'(sel2[k]);
      step(2);
      s0 = n1;
      s1 = tn;
      s2 = zn;
      step(48);
      check(16'(n1 - s0), 16'(rate1[k]));
      check(16'(zn - s2), 16'(rate1[k]));
      check(16'(tn - s1), 16'(rate2[k]));
    end
    zc.run = 1'b0;
    osel = 1'b0;
    pre = tmrclk_pkg::PRE_EXT8;
    tc.clk_sel = tmrclk_pkg::SRC_EXT8;
    hc = '{1'b1, 1'b0, tmrclk_pkg::SRC_EXT8, 1'b0};
    step(2);
    s0 = n1;
    s1 = tn;
    s2 = hn;
    i_far.osc_edges(2 * EXT_N);
    step(8);
    check(16'(n1 - s0), 16'h0002);
    check(16'(tn - s1), 16'h0002);
    check(16'(hn - s2), 16'h0002);
    oc.run = 1'b0;
    $display("test clocks done");
    trl = 16'hFFFE;
    sbus = tmrclk_pkg::SBUS_TWO_HI;
    tc = '{1'b1, 1'b0, tmrclk_pkg::SRC_SYS, 1'b0};
    tl = '{1'b1, 16'hFFFF};
    step(1);
    tl.strobe = 1'b0;
    step(1);
    check(tn, 16'hFFFE);
    check({tho, tlo}, 2'h3);
    sbus = tmrclk_pkg::SBUS_TWO_LO;
    step(1);
    tc.run = 1'b0;
    check(tn, 16'hFFFF);
    check({sclk, tho, tlo}, 3'h4);
    hrl = 16'h1020;
    hc = '{1'b1, 1'b1, tmrclk_pkg::SRC_SYS, 1'b0};
    hl = '{1'b1, 16'hFFFF};
    step(1);
    hl.strobe = 1'b0;
    step(1);
    hc.run = 1'b0;
    check(hn, 16'h1020);
    check({hho, hlo}, 2'h3);
    step(1);
    check(stmo, 1'b1);
    step(1);
    check(hn, 16'h1022);
    $display("test reload done");
    v = $random(seed) & 32'hFFFF;
    tc = '{1'b0, 1'b0, tmrclk_pkg::tmrclk_src_t'(3), 1'b1};
    hc = tc;
    tl = '{1'b1, 16'(v)};
    hl = '{1'b1, ~16'(v)};
    step(1);
    tl.strobe = 1'b0;
    hl.strobe = 1'b0;
    i_far.pulse(1'b0);
    i_far.pulse(1'b1);
    step(4);
    check(tcap, 16'(v));
    check(hcap, ~16'(v));
    tc.cap_en = 1'b0;
    tl = '{1'b1, 16'h0000};
    step(1);
    tl.strobe = 1'b0;
    i_far.pulse(1'b0);
    step(4);
    check(tcap, 16'(v));
    $display("test capture done");
    finish_test();
  end
endmodule

`default_nettype wire
